// ### include/rpes_map.svh
// register-free constants for the repeater port statistics block
`ifndef RPES_MAP_SVH
`define RPES_MAP_SVH
// ****************************************************************
// durations in bit times
// ****************************************************************
`define RPES_SHORT_10_BT     16'h004E
`define RPES_SHORT_100_BT    16'h0054
`define RPES_VALID_FLOOR_BT  16'h0228
`define RPES_LATE_BT         16'h0228
`define RPES_JABBER_BT       16'h1F40
// ****************************************************************
// frame sizes in bytes, then the zero and one constants
// ****************************************************************
`define RPES_RUNT_BYTES      16'h0040
`define RPES_RATE_MIN_BYTES  16'h003F
`define RPES_LEN_MIN         16'h0040
`define RPES_LEN_MAX         16'h05EE
`define RPES_ZERO            32'h0000_0000
`define RPES_ONE             32'h0000_0001
`endif

// ### include/rpes_pkg.sv
// types for the repeater port statistics block
package rpes_pkg;
  typedef enum logic [1:0] {
    RPES_IDLE  = 2'b00,
    RPES_ACT   = 2'b01,
    RPES_CLOSE = 2'b11
  } rpes_state_t;
  typedef logic [15:0] rpes_len_t;
endpackage : rpes_pkg

// ### rtl/rpes_counter.sv
// free-running wrapping event counter
`timescale 1ns/1ps
`default_nettype none
`include "rpes_map.svh"
module rpes_counter #(
  parameter int WIDTH = 32
) (
  input  wire logic             sys_clk,
  input  wire logic             bump,
  output logic [WIDTH-1:0]      count
);
  initial begin
    if (WIDTH < 1 || WIDTH > 32) $error("rpes_counter: bad WIDTH");
  end
  logic [WIDTH-1:0] count_reg = '0;
  // no reset: counts survive repeater reset
  always_ff @(posedge sys_clk) begin
    if (bump) begin
      count_reg <= count_reg + WIDTH'(`RPES_ONE);
    end
  end
  assign count = count_reg;
endmodule : rpes_counter
`default_nettype wire

// ### rtl/rpes_edge.sv
// rising-edge detector giving a one-cycle entry pulse
`timescale 1ns/1ps
`default_nettype none
module rpes_edge (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic level,
  output logic      rise
);
  logic level_reg;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      level_reg <= 1'b0;
    end else begin
      level_reg <= level;
    end
  end
  // an entry seen while in reset gives no pulse, but a level still high when reset ends pulses in the first cycle after
  assign rise = level & ~level_reg & ~rst;
endmodule : rpes_edge
`default_nettype wire

// ### rtl/rpes_stats.sv
// per-port error statistics for a shared-medium repeater port
// Functional notes
// - count alignment errors: in-range, checksum+framing bad, no collision
// - alignment error frame skips checksum error count
// - count frames longer than maximum length
// - oversize frame skips alignment and checksum counts
// - count carrier events shorter than short limit
// - 100 Mb/s short limit is 84 bits
// - runt: above short, below valid floor, no collision
// - alternative runt test by byte count unused
// - valid packet floor is 552 bit times
// - 74..82 BT event hits short or runt only
// - 10 Mb/s collision counted per collided carrier event
// - 100 Mb/s collision counted on collision-increment entry
// - 10 Mb/s late event on late signal quality error
// - 100 Mb/s late entry counts collision and late
// - late threshold 552 BT has its own comparator (above 552), apart from the floor one (552 and up)
// - 10 Mb/s very long beyond jabber lockup timer
// - 100 Mb/s very long on receive-jabber entry
// - rate mismatch: no collision, above floor, mismatched
// - byte-count rate mismatch method unused
// - auto partition counted on partition-wait entry
// - isolation counted on false carrier to link shaky
// - isolation never touches admin setting
`timescale 1ns/1ps
`default_nettype none
`include "rpes_map.svh"
module rpes_stats #(
  parameter int CW         = 32,
  parameter int JABBER_BT  = 16'h1F40
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        mode_100,
  input  wire logic        carrier_activity,
  input  wire logic        bit_tick,
  input  wire logic        frame_done,
  input  wire logic [15:0] frame_byte_count,
  input  wire logic        checksum_bad,
  input  wire logic        framing_bad,
  input  wire logic        collision_seen,
  input  wire logic        any_port_carrier,
  input  wire logic        port_collision_input,
  input  wire logic        coll_incr_state,
  input  wire logic        rx_jabber_state,
  input  wire logic        partition_wait_state,
  input  wire logic        false_carrier_state,
  input  wire logic        link_shaky_state,
  input  wire logic        rate_mismatch,
  input  wire logic        admin_enable_in,
  output logic             port_admin_setting,
  output logic [CW-1:0]    align_err_count,
  output logic [CW-1:0]    checksum_err_count,
  output logic [CW-1:0]    oversize_frame_count,
  output logic [CW-1:0]    short_event_count,
  output logic [CW-1:0]    runt_count,
  output logic [CW-1:0]    collision_count,
  output logic [CW-1:0]    late_event_count,
  output logic [CW-1:0]    very_long_event_count,
  output logic [CW-1:0]    rate_mismatch_count,
  output logic [CW-1:0]    auto_partition_count,
  output logic [CW-1:0]    isolate_count
);
  initial begin
    if (CW < 8 || CW > 32) $error("rpes_stats: bad CW");
    if (JABBER_BT < 1 || JABBER_BT > 65534) $error("rpes_stats: bad jabber");
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic ge_len(input rpes_pkg::rpes_len_t a,
                                  input rpes_pkg::rpes_len_t b);
    ge_len = (a >= b);
  endfunction : ge_len

  // ****************************************************************
  // activity length measurement
  // ****************************************************************
  rpes_pkg::rpes_state_t   state_reg;
  rpes_pkg::rpes_len_t     act_len_reg;
  logic                    coll_evt_reg;
  logic                    coll_incr_reg;
  logic                    vlong_done_reg;
  logic                    coll_pulse;
  logic                    jab_pulse;
  logic                    part_pulse;
  logic                    isol_pulse;
  logic                    fc_reg;
  logic                    carrier_end;
  logic                    any_end;
  logic                    any_reg;
  logic                    sqe_pulse;
  logic                    any_coll_reg;
  rpes_pkg::rpes_len_t     short_lim;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_reg <= rpes_pkg::RPES_IDLE;
    end else begin
      case (state_reg)
        rpes_pkg::RPES_IDLE: begin
          if (carrier_activity) state_reg <= rpes_pkg::RPES_ACT;
        end
        rpes_pkg::RPES_ACT: begin
          if (!carrier_activity) state_reg <= rpes_pkg::RPES_CLOSE;
        end
        rpes_pkg::RPES_CLOSE: state_reg <= rpes_pkg::RPES_IDLE;
        default: state_reg <= rpes_pkg::RPES_IDLE;
      endcase
    end
  end
  assign carrier_end = (state_reg == rpes_pkg::RPES_CLOSE);

  // saturate so a stuck carrier cannot wrap back into short range
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      act_len_reg <= '0;
    end else if (state_reg == rpes_pkg::RPES_IDLE) begin
      // the tick that opens the event is its first bit time
      act_len_reg <= (carrier_activity && bit_tick) ? 16'h0001 : 16'h0000;
    end else if (state_reg == rpes_pkg::RPES_ACT && bit_tick
                 && act_len_reg != 16'hFFFF) begin
      act_len_reg <= act_len_reg + 16'h0001;
    end
  end

  // per-event collision memory
  always_ff @(posedge sys_clk) begin
    // a collision between events must not mark the next event
    if (rst || state_reg == rpes_pkg::RPES_CLOSE
        || (state_reg == rpes_pkg::RPES_IDLE && !carrier_activity)) begin
      coll_evt_reg  <= 1'b0;
      coll_incr_reg <= 1'b0;
    end else begin
      if (collision_seen) coll_evt_reg <= 1'b1;
      if (coll_pulse) coll_incr_reg <= 1'b1;
    end
  end

  assign short_lim = mode_100 ? `RPES_SHORT_100_BT
                              : `RPES_SHORT_10_BT;

  logic is_short;
  logic above_floor;
  logic no_coll;
  logic is_late;
  assign is_short    = !ge_len(act_len_reg, short_lim);
  assign above_floor = ge_len(act_len_reg, `RPES_VALID_FLOOR_BT);
  assign is_late     = act_len_reg > `RPES_LATE_BT;
  assign no_coll     = mode_100 ? !coll_incr_reg : !coll_evt_reg;

  // ****************************************************************
  // state entry pulses
  // ****************************************************************
  rpes_edge u_coll (.sys_clk(sys_clk), .rst(rst),
                    .level(coll_incr_state), .rise(coll_pulse));
  rpes_edge u_jab  (.sys_clk(sys_clk), .rst(rst),
                    .level(rx_jabber_state), .rise(jab_pulse));
  rpes_edge u_part (.sys_clk(sys_clk), .rst(rst),
                    .level(partition_wait_state), .rise(part_pulse));
  rpes_edge u_sqe  (.sys_clk(sys_clk), .rst(rst),
                    .level(port_collision_input), .rise(sqe_pulse));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fc_reg <= 1'b0;
    end else begin
      fc_reg <= false_carrier_state;
    end
  end
  assign isol_pulse = fc_reg & link_shaky_state & ~false_carrier_state;

  // repeater-wide carrier event, for the 10 Mb/s collision count
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      any_reg      <= 1'b0;
      any_coll_reg <= 1'b0;
    end else begin
      any_reg <= any_port_carrier;
      if (any_end) any_coll_reg <= 1'b0;
      else if (any_port_carrier && port_collision_input) any_coll_reg <= 1'b1;
    end
  end
  assign any_end = any_reg & ~any_port_carrier;

  // very long: once per event at the jabber time
  always_ff @(posedge sys_clk) begin
    if (rst || state_reg == rpes_pkg::RPES_IDLE) begin
      vlong_done_reg <= 1'b0;
    end else if (act_len_reg > 16'(JABBER_BT)) begin
      vlong_done_reg <= 1'b1;
    end
  end

  // ****************************************************************
  // counter bump terms
  // ****************************************************************
  logic in_range;
  logic oversize;
  logic b_align;
  logic b_fcs;
  logic b_over;
  logic b_short;
  logic b_runt;
  logic b_coll;
  logic b_late;
  logic b_vlong;
  logic b_rate;
  assign oversize = frame_byte_count > `RPES_LEN_MAX;
  assign in_range = ge_len(frame_byte_count, `RPES_LEN_MIN) && !oversize;
  assign b_over   = frame_done && oversize;
  assign b_align  = frame_done && in_range && checksum_bad
                    && framing_bad && !collision_seen;
  assign b_fcs    = frame_done && in_range && checksum_bad
                    && !framing_bad && !collision_seen;
  assign b_short  = carrier_end && is_short;
  assign b_runt   = carrier_end && !is_short && !above_floor
                    && no_coll;
  assign b_coll   = mode_100 ? coll_pulse
                             : (any_end && any_coll_reg);
  assign b_late   = mode_100 ? (coll_pulse && is_late)
                             : (sqe_pulse && is_late
                                && state_reg == rpes_pkg::RPES_ACT);
  assign b_vlong  = mode_100 ? jab_pulse
                             : (!vlong_done_reg
                                && act_len_reg > 16'(JABBER_BT));
  assign b_rate   = carrier_end && above_floor && no_coll
                    && rate_mismatch;
  // admin setting passes straight from management; isolation has no path
  assign port_admin_setting = admin_enable_in;

  // ****************************************************************
  // counters
  // ****************************************************************
  rpes_counter #(.WIDTH(CW)) u_c0 (.sys_clk(sys_clk), .bump(b_align),
                                   .count(align_err_count));
  rpes_counter #(.WIDTH(CW)) u_c1 (.sys_clk(sys_clk), .bump(b_fcs),
                                   .count(checksum_err_count));
  rpes_counter #(.WIDTH(CW)) u_c2 (.sys_clk(sys_clk), .bump(b_over),
                                   .count(oversize_frame_count));
  rpes_counter #(.WIDTH(CW)) u_c3 (.sys_clk(sys_clk), .bump(b_short),
                                   .count(short_event_count));
  rpes_counter #(.WIDTH(CW)) u_c4 (.sys_clk(sys_clk), .bump(b_runt),
                                   .count(runt_count));
  rpes_counter #(.WIDTH(CW)) u_c5 (.sys_clk(sys_clk), .bump(b_coll),
                                   .count(collision_count));
  rpes_counter #(.WIDTH(CW)) u_c6 (.sys_clk(sys_clk), .bump(b_late),
                                   .count(late_event_count));
  rpes_counter #(.WIDTH(CW)) u_c7 (.sys_clk(sys_clk), .bump(b_vlong),
                                   .count(very_long_event_count));
  rpes_counter #(.WIDTH(CW)) u_c8 (.sys_clk(sys_clk), .bump(b_rate),
                                   .count(rate_mismatch_count));
  rpes_counter #(.WIDTH(CW)) u_c9 (.sys_clk(sys_clk), .bump(part_pulse),
                                   .count(auto_partition_count));
  rpes_counter #(.WIDTH(CW)) u_ca (.sys_clk(sys_clk), .bump(isol_pulse),
                                   .count(isolate_count));

  // ****************************************************************
  // assertions
  // ****************************************************************
  property p_align_not_fcs;
    @(posedge sys_clk) disable iff (rst) b_align |-> !b_fcs;
  endproperty
  a_align_not_fcs: assert property (p_align_not_fcs)
    else $error("alignment and checksum both counted");

  property p_over_excl;
    @(posedge sys_clk) disable iff (rst) b_over |-> !b_align && !b_fcs;
  endproperty
  a_over_excl: assert property (p_over_excl)
    else $error("oversize frame also counted as error");

  property p_align_step;
    @(posedge sys_clk) disable iff (rst)
      b_align |=> align_err_count == $past(align_err_count) + CW'(1);
  endproperty
  a_align_step: assert property (p_align_step)
    else $error("alignment count did not step");

  property p_short_runt;
    @(posedge sys_clk) disable iff (rst) !(b_short && b_runt);
  endproperty
  a_short_runt: assert property (p_short_runt)
    else $error("short and runt both counted");

  property p_short_len;
    @(posedge sys_clk) disable iff (rst)
      b_short |-> act_len_reg < (mode_100 ? 16'h0054 : 16'h004E);
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("short event too long");

  property p_late_coll;
    @(posedge sys_clk) disable iff (rst)
      (mode_100 && b_late) |-> b_coll;
  endproperty
  a_late_coll: assert property (p_late_coll)
    else $error("late entry missed collision count");

  property p_part_step;
    @(posedge sys_clk) disable iff (rst)
      $rose(partition_wait_state) |=> auto_partition_count
        == $past(auto_partition_count) + CW'(1);
  endproperty
  a_part_step: assert property (p_part_step)
    else $error("partition not counted");

  property p_isol_step;
    @(posedge sys_clk) disable iff (rst)
      ($fell(false_carrier_state) && link_shaky_state)
        |=> isolate_count == $past(isolate_count) + CW'(1);
  endproperty
  a_isol_step: assert property (p_isol_step)
    else $error("isolation not counted");

  property p_admin;
    @(posedge sys_clk) disable iff (rst)
      port_admin_setting == admin_enable_in;
  endproperty
  a_admin: assert property (p_admin)
    else $error("admin setting disturbed");

  property p_runt_nocoll;
    @(posedge sys_clk) disable iff (rst) b_runt |-> no_coll && !above_floor;
  endproperty
  a_runt_nocoll: assert property (p_runt_nocoll)
    else $error("runt counted with collision");

  property p_align_hold;
    @(posedge sys_clk) disable iff (rst)
      !b_align |=> align_err_count == $past(align_err_count);
  endproperty
  a_align_hold: assert property (p_align_hold)
    else $error("alignment count moved without an event");

  c_short: cover property (@(posedge sys_clk) b_short);
  c_runt:  cover property (@(posedge sys_clk) b_runt);
  c_late:  cover property (@(posedge sys_clk) b_late && b_coll);
  c_over:  cover property (@(posedge sys_clk) b_over);
  c_isol:  cover property (@(posedge sys_clk) isol_pulse);
endmodule : rpes_stats
`default_nettype wire

// ### verification/rpes_partner.sv
// receive side model: carrier events with bit ticks and a collision hit
`timescale 1ns/1ps
`default_nettype none
module rpes_partner (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        go,
  input  wire logic [15:0] len,
  input  wire logic [15:0] hit_at,
  output logic             carrier_activity,
  output logic             bit_tick,
  output logic             any_port_carrier,
  output logic             hit
);
  logic [15:0] left_reg;
  logic [15:0] age_reg;
  // ****************************************************************
  // event length and age, one bit time per clock
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      left_reg <= 16'h0000;
      age_reg  <= 16'h0000;
    end else if (go) begin
      left_reg <= len;
      age_reg  <= 16'h0000;
    end else if (left_reg != 16'h0000) begin
      left_reg <= left_reg - 16'h0001;
      age_reg  <= age_reg + 16'h0001;
    end
  end
  // ticks stand still between events, as a real receiver would
  assign carrier_activity = (left_reg != 16'h0000);
  assign bit_tick         = carrier_activity;
  assign any_port_carrier = carrier_activity;
  // hit is a level that stays up until the event ends
  assign hit = carrier_activity && (hit_at != 16'h0000) && (age_reg >= hit_at);
endmodule : rpes_partner
`default_nettype wire

// ### verification/rpes_stats_test.sv
// self-checking bench for the repeater port statistics block
`timescale 1ns/1ps
`default_nettype none
module rpes_stats_test;
  typedef int rpes_delta_t [11];
  logic        sys_clk, rst, mode_100, frame_done, checksum_bad;
  logic        framing_bad, collision_seen, rx_jabber_state;
  logic        partition_wait_state, false_carrier_state, go;
  logic        link_shaky_state, rate_mismatch, admin_enable_in;
  logic [15:0] frame_byte_count, len, hit_at;
  wire logic   carrier_activity, bit_tick, any_port_carrier, hit;
  wire logic   port_admin_setting, port_collision_input, coll_incr_state;
  wire logic [31:0] cnt [11];
  logic [31:0] base [11];
  int          miscompares, num_checks;
  assign port_collision_input = hit & ~mode_100;
  assign coll_incr_state      = hit & mode_100;
  rpes_partner peer_u (.sys_clk, .rst, .go, .len, .hit_at,
    .carrier_activity, .bit_tick, .any_port_carrier, .hit);
  rpes_stats #(.CW(32), .JABBER_BT(700)) dut_u (
    .sys_clk, .rst, .mode_100, .carrier_activity, .bit_tick, .frame_done,
    .frame_byte_count, .checksum_bad, .framing_bad, .collision_seen,
    .any_port_carrier, .port_collision_input, .coll_incr_state,
    .rx_jabber_state, .partition_wait_state, .false_carrier_state,
    .link_shaky_state, .rate_mismatch, .admin_enable_in,
    .port_admin_setting, .align_err_count(cnt[0]),
    .checksum_err_count(cnt[1]), .oversize_frame_count(cnt[2]),
    .short_event_count(cnt[3]), .runt_count(cnt[4]),
    .collision_count(cnt[5]), .late_event_count(cnt[6]),
    .very_long_event_count(cnt[7]), .rate_mismatch_count(cnt[8]),
    .auto_partition_count(cnt[9]), .isolate_count(cnt[10]));
  always #50 sys_clk = ~sys_clk;
  // ****************************************************************
  // comparison and verdict
  // ****************************************************************
  task automatic give_verdict;
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk_cnt(input int i, input logic [31:0] exp);
    num_checks++;
    if (cnt[i] !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, cnt[i], exp);
    end
  endtask : chk_cnt
  task automatic chk_bit(input logic exp);
    num_checks++;
    if (port_admin_setting !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time,
               port_admin_setting, exp);
    end
  endtask : chk_bit
  // every counter is checked each time, so a stray extra count shows too
  task automatic sweep(input rpes_delta_t d);
    for (int i = 0; i < 11; i++) begin
      chk_cnt(i, base[i] + d[i]);
    end
    base = cnt;
  endtask : sweep
  // ****************************************************************
  // stimulus helpers
  // ****************************************************************
  task automatic ev(input logic [15:0] n, input logic [15:0] h);
    int k;
    @(negedge sys_clk);
    len = n;
    hit_at = h;
    go = 1'b1;
    @(negedge sys_clk);
    go = 1'b0;
    k = 0;
    while (carrier_activity === 1'b1 && k < 4000) begin
      @(negedge sys_clk);
      k++;
    end
    if (k >= 4000) begin
      miscompares++;
      give_verdict();
    end else begin
      repeat (4) @(negedge sys_clk);
    end
  endtask : ev
  task automatic fr(input logic [15:0] n, input logic c, f, col);
    @(negedge sys_clk);
    frame_byte_count = n;
    checksum_bad = c;
    framing_bad = f;
    collision_seen = col;
    frame_done = 1'b1;
    @(negedge sys_clk);
    frame_done = 1'b0;
    collision_seen = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask : fr
  task automatic pulse_state(ref logic s, input int n);
    @(negedge sys_clk);
    s = 1'b1;
    repeat (n) @(negedge sys_clk);
    s = 1'b0;
    repeat (3) @(negedge sys_clk);
  endtask : pulse_state
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_frames;
    fr(16'h0040, 1'b1, 1'b1, 1'b0);
    sweep('{1, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    fr(16'h0100, 1'b1, 1'b0, 1'b0);
    sweep('{0, 1, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    fr(16'h05EE, 1'b1, 1'b1, 1'b1);
    sweep('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    fr(16'h003F, 1'b1, 1'b1, 1'b0);
    sweep('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    fr(16'h05EF, 1'b1, 1'b1, 1'b0);
    sweep('{0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 0});
  endtask : t_frames
  task automatic t_slow;
    mode_100 = 1'b0;
    ev(16'h004C, 16'h0000);
    sweep('{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0});
    ev(16'h0050, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    ev(16'h004D, 16'h0000);
    sweep('{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0});
    ev(16'h004E, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    ev(16'h021C, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    collision_seen = 1'b1;
    ev(16'h00C8, 16'h000A);
    sweep('{0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0});
    ev(16'h028A, 16'h0258);
    sweep('{0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0});
    collision_seen = 1'b0;
    rate_mismatch = 1'b1;
    ev(16'h02D0, 16'h0000);
    sweep('{0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0});
    ev(16'h012C, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    rate_mismatch = 1'b0;
  endtask : t_slow
  task automatic t_fast;
    mode_100 = 1'b1;
    ev(16'h0052, 16'h0000);
    sweep('{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0});
    ev(16'h0056, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    ev(16'h0053, 16'h0000);
    sweep('{0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0});
    ev(16'h0054, 16'h0000);
    sweep('{0, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0});
    ev(16'h00C8, 16'h000A);
    sweep('{0, 0, 0, 0, 0, 1, 0, 0, 0, 0, 0});
    ev(16'h028A, 16'h0258);
    sweep('{0, 0, 0, 0, 0, 1, 1, 0, 0, 0, 0});
    pulse_state(rx_jabber_state, 3);
    sweep('{0, 0, 0, 0, 0, 0, 0, 1, 0, 0, 0});
    pulse_state(partition_wait_state, 6);
    sweep('{0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 0});
  endtask : t_fast
  task automatic t_isolate;
    pulse_state(false_carrier_state, 3);
    sweep('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0});
    link_shaky_state = 1'b1;
    pulse_state(false_carrier_state, 3);
    sweep('{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1});
    chk_bit(1'b1);
    link_shaky_state = 1'b0;
    admin_enable_in = 1'b0;
    @(negedge sys_clk);
    chk_bit(1'b0);
  endtask : t_isolate
  initial begin
    {sys_clk, mode_100, frame_done, checksum_bad, framing_bad} = 5'h0_0;
    {collision_seen, rx_jabber_state, partition_wait_state, go} = 4'h0;
    {false_carrier_state, link_shaky_state, rate_mismatch} = 3'h0;
    {frame_byte_count, len, hit_at} = 48'h0000_0000_0000;
    admin_enable_in = 1'b1;
    miscompares = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    base = cnt;
    t_frames();
    t_slow();
    t_fast();
    t_isolate();
    give_verdict();
  end
endmodule : rpes_stats_test
`default_nettype wire
